// ==== ecf_clock_ctrl.v ====
// Summary of operation
// - Accept external reference 31.25 kHz to 5 MHz
// - Output enable drives reference onto output
// - Internal select keeps external off FLL reference
// - Both enables keep external output through stop
// - Divided FLL reference drives fixed-frequency clock
// - Valid when generator at least four times fixed
// - Engaged mode holds valid high always
// - Bypass: divider 00/01 need reference 010/011
// - Bypass: divider 10/11 need 100/101, else low
// - Source 00 engaged, 01 internal, 10 external
// - Stop halts fixed and generator clocks; external output runs on if both enables set
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ecf_consts.vh"

module ecf_clock_ctrl #(
  parameter INT_REF_HALF_CYC = `ECF_INT_REF_HALF_CYC,
  parameter DIV_CNT_W        = 7
) (
  input  wire       MCLK_I,
  input  wire       NRST_I,
  input  wire [7:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  input  wire       EXT_REF_I,
  input  wire       FLL_CLK_I,
  input  wire       STOP_I,
  output reg        EXT_REF_CLOCK_OUT_O,
  output wire       FIXED_FREQ_CLOCK_O,
  output wire       FIXED_FREQ_VALID_O,
  output wire       GENERATOR_OUTPUT_CLOCK_O,
  output wire [1:0] CLOCK_SOURCE_SEL_O,
  output wire       INTERNAL_REF_SELECT_O,
  output wire [2:0] REF_DIVIDER_SEL_O,
  output wire [1:0] BUS_DIVIDER_SEL_O
);

  localparam integer MON_TIMEOUT_N = `ECF_EXT_TIMEOUT_CYC;
  localparam integer MON_MIN_N     = `ECF_EXT_MIN_CYC;
  localparam integer IREF_LAST_N   = INT_REF_HALF_CYC - 1;
  localparam [9:0]   MON_TIMEOUT   = MON_TIMEOUT_N[9:0];
  localparam [9:0]   MON_MIN       = MON_MIN_N[9:0];
  localparam [9:0]   MON_ONE       = 10'h001;
  localparam [8:0]   IREF_LAST     = IREF_LAST_N[8:0];

  // Mode states, one-hot
  localparam [2:0] ST_ENGAGED = 3'h1;
  localparam [2:0] ST_BYP_INT = 3'h2;
  localparam [2:0] ST_BYP_EXT = 3'h4;

  reg  [7:0] ctrl;
  reg  [7:0] div;
  reg  [1:0] flags;
  reg  [7:0] next_rdata;
  reg  [2:0] mode;

  wire       ext_out_en;
  wire       ext_stop_en;
  wire       iref_sel;
  wire [1:0] clock_source_sel;
  wire [2:0] ref_divider_sel;
  wire [1:0] bus_divider_sel;

  assign ext_out_en  = ctrl[`ECF_CTRL_OUT_EN];
  assign ext_stop_en = ctrl[`ECF_CTRL_STOP_EN];
  assign iref_sel    = ctrl[`ECF_CTRL_IREF_SEL];
  assign clock_source_sel        = ctrl[`ECF_CTRL_CLOCK_SOURCE_SEL_HI:`ECF_CTRL_CLOCK_SOURCE_SEL_LO];
  assign ref_divider_sel        = div[`ECF_DIV_REF_DIVIDER_SEL_HI:`ECF_DIV_REF_DIVIDER_SEL_LO];
  assign bus_divider_sel        = div[`ECF_DIV_BUS_DIVIDER_SEL_HI:`ECF_DIV_BUS_DIVIDER_SEL_LO];

  assign CLOCK_SOURCE_SEL_O    = clock_source_sel;
  assign INTERNAL_REF_SELECT_O = iref_sel;
  assign REF_DIVIDER_SEL_O     = ref_divider_sel;
  assign BUS_DIVIDER_SEL_O     = bus_divider_sel;

  // Mode decode from clock source select
  always @* begin
    case (clock_source_sel)
      `ECF_CLOCK_SOURCE_SEL_FLL: mode = ST_ENGAGED;
      `ECF_CLOCK_SOURCE_SEL_INT: mode = ST_BYP_INT;
      `ECF_CLOCK_SOURCE_SEL_EXT: mode = ST_BYP_EXT;
      default:       mode = 3'h0;
    endcase
  end

  // External reference pin synchroniser
  reg ext_s1;
  reg ext_s2;
  reg ext_s3;

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= EXT_REF_I;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  wire ext_edge;
  wire ext_rise;

  assign ext_edge = ext_s2 ^ ext_s3;
  assign ext_rise = ext_s2 & ~ext_s3;

  // Stop gating of each clock
  wire ext_out_run;
  wire ext_wanted;
  wire ext_run;
  wire run_normal;

  assign run_normal  = ~STOP_I;
  assign ext_out_run = ext_out_en & (run_normal | ext_stop_en);
  assign ext_wanted  = ext_out_en | ~iref_sel | (mode == ST_BYP_EXT);
  assign ext_run     = ext_wanted & (run_normal | ext_out_run);

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      EXT_REF_CLOCK_OUT_O <= 1'b0;
    end else begin
      EXT_REF_CLOCK_OUT_O <= ext_s2 & ext_out_run;
    end
  end

  // External reference presence monitor
  reg [9:0] mon_cnt;
  wire      ext_present;
  wire      ext_too_fast;

  assign ext_present  = ext_run & (mon_cnt < MON_TIMEOUT);
  assign ext_too_fast = ext_run & ext_rise & (mon_cnt < MON_MIN - MON_ONE);

  always @(posedge MCLK_I) begin
    if (!NRST_I || !ext_run) begin
      mon_cnt <= MON_TIMEOUT;
    end else if (ext_rise) begin
      mon_cnt <= 10'h000;
    end else if (mon_cnt < MON_TIMEOUT) begin
      mon_cnt <= mon_cnt + MON_ONE;
    end
  end

  reg ext_present_d;

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      ext_present_d <= 1'b0;
    end else begin
      ext_present_d <= ext_present;
    end
  end

  // Internal reference oscillator
  reg [8:0] iref_cnt;
  reg       iref_edge;
  wire      iref_run;

  assign iref_run = run_normal & (iref_sel | (mode == ST_BYP_INT));

  always @(posedge MCLK_I) begin
    if (!NRST_I || !iref_run) begin
      iref_cnt  <= 9'h000;
      iref_edge <= 1'b0;
    end else if (iref_cnt == IREF_LAST) begin
      iref_cnt  <= 9'h000;
      iref_edge <= 1'b1;
    end else begin
      iref_cnt  <= iref_cnt + 9'h001;
      iref_edge <= 1'b0;
    end
  end

  // FLL reference select and fixed-frequency divider
  wire ref_edge;

  assign ref_edge = iref_sel ? iref_edge : ext_edge;

  ecf_edge_div #(
    .CNT_W (DIV_CNT_W),
    .SEL_W (3)
  ) u_ref_div (
    .clk_i  (MCLK_I),
    .nrst_i (NRST_I),
    .run_i  (run_normal),
    .edge_i (ref_edge),
    .sel_i  (ref_divider_sel),
    .clk_o  (FIXED_FREQ_CLOCK_O)
  );

  // Generator output clock from the selected source
  reg fll_d;

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      fll_d <= 1'b0;
    end else begin
      fll_d <= FLL_CLK_I;
    end
  end

  reg gen_edge;

  always @* begin
    case (mode)
      ST_ENGAGED: gen_edge = FLL_CLK_I ^ fll_d;
      ST_BYP_INT: gen_edge = iref_edge;
      ST_BYP_EXT: gen_edge = ext_edge;
      default:    gen_edge = 1'b0;
    endcase
  end

  ecf_edge_div #(
    .CNT_W (DIV_CNT_W),
    .SEL_W (2)
  ) u_bus_div (
    .clk_i  (MCLK_I),
    .nrst_i (NRST_I),
    .run_i  (run_normal),
    .edge_i (gen_edge),
    .sel_i  (bus_divider_sel),
    .clk_o  (GENERATOR_OUTPUT_CLOCK_O)
  );

  // Fixed-frequency valid flag
  reg ffv;

  always @* begin
    case (mode)
      ST_ENGAGED: ffv = 1'b1;
      ST_BYP_INT,
      ST_BYP_EXT: ffv = (ref_divider_sel >= ({1'b0, bus_divider_sel} + `ECF_FFV_REF_DIVIDER_SEL_OFFSET));
      default:    ffv = 1'b0;
    endcase
  end

  assign FIXED_FREQ_VALID_O = ffv;

  // Register writes
  wire wr_ctrl;
  wire wr_div;
  wire wr_flags;

  assign wr_ctrl  = WR_I & (ADDR_I == `ECF_ADDR_CTRL);
  assign wr_div   = WR_I & (ADDR_I == `ECF_ADDR_DIV);
  assign wr_flags = WR_I & (ADDR_I == `ECF_ADDR_FLAGS);

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      ctrl <= `ECF_CTRL_RESET;
      div  <= `ECF_DIV_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {3'h0, WDATA_I[`ECF_CTRL_CLOCK_SOURCE_SEL_HI:0]};
      end
      if (wr_div) begin
        div <= {2'h0, WDATA_I[`ECF_DIV_BUS_DIVIDER_SEL_HI:`ECF_DIV_BUS_DIVIDER_SEL_LO], 1'b0,
                WDATA_I[`ECF_DIV_REF_DIVIDER_SEL_HI:`ECF_DIV_REF_DIVIDER_SEL_LO]};
      end
    end
  end

  // Sticky flags, write one to clear, a new event wins
  wire [1:0] flag_set;
  wire [1:0] flag_clr;

  assign flag_set = {ext_too_fast, ext_present_d & ~ext_present & ext_run};
  assign flag_clr = wr_flags ? WDATA_I[`ECF_FLAG_EXT_FAST:`ECF_FLAG_EXT_LOST] : 2'h0;

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      flags <= 2'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // Register reads, data valid in the following cycle only
  always @* begin
    next_rdata = 8'h00;
    case (ADDR_I)
      `ECF_ADDR_CTRL:  next_rdata = ctrl;
      `ECF_ADDR_DIV:   next_rdata = div;
      `ECF_ADDR_STATUS: begin
        next_rdata[`ECF_STAT_FFV]         = ffv;
        next_rdata[`ECF_STAT_EXT_PRESENT] = ext_present;
        next_rdata[`ECF_STAT_STOP]        = STOP_I;
        next_rdata[`ECF_STAT_EXT_OUT_ON]  = ext_out_run;
        next_rdata[`ECF_STAT_ENGAGED]     = (mode == ST_ENGAGED);
      end
      `ECF_ADDR_FLAGS: next_rdata = {6'h00, flags};
      default:         next_rdata = 8'h00;
    endcase
  end

  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= next_rdata;
    end else begin
      RDATA_O <= 8'h00;
    end
  end

endmodule // ecf_clock_ctrl

// ==== ecf_clock_ctrl_props.sv ====
`timescale 1ns/1ps
`include "ecf_consts.vh"
module ecf_clock_ctrl_props (
  input wire       MCLK_I,
  input wire       NRST_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       STOP_I,
  input wire       EXT_REF_I,
  input wire       EXT_REF_CLOCK_OUT_O,
  input wire       FIXED_FREQ_CLOCK_O,
  input wire       FIXED_FREQ_VALID_O,
  input wire       GENERATOR_OUTPUT_CLOCK_O,
  input wire [1:0] CLOCK_SOURCE_SEL_O,
  input wire [2:0] REF_DIVIDER_SEL_O,
  input wire [1:0] BUS_DIVIDER_SEL_O
);
  logic en_out;
  logic en_stop;
  wire  gate = en_out && (en_stop || !STOP_I);
  wire  byp  = (CLOCK_SOURCE_SEL_O == 2'h1) || (CLOCK_SOURCE_SEL_O == 2'h2);
  wire  ok   = (BUS_DIVIDER_SEL_O == 2'h0) ? (REF_DIVIDER_SEL_O >= 3'h2) :
               (BUS_DIVIDER_SEL_O == 2'h1) ? (REF_DIVIDER_SEL_O >= 3'h3) :
               (BUS_DIVIDER_SEL_O == 2'h2) ? (REF_DIVIDER_SEL_O >= 3'h4) :
                                             (REF_DIVIDER_SEL_O >= 3'h5);
  // Shadow of the two enables
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      en_out  <= 1'b0;
      en_stop <= 1'b0;
    end else if (WR_I && ADDR_I == `ECF_ADDR_CTRL) begin
      en_out  <= WDATA_I[`ECF_CTRL_OUT_EN];
      en_stop <= WDATA_I[`ECF_CTRL_STOP_EN];
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_gate_held; gate [*4]; endsequence
  sequence s_gate_off; (!gate) [*2]; endsequence
  sequence s_stopped; STOP_I [*2]; endsequence
  a_valid_engaged: assert property (
    CLOCK_SOURCE_SEL_O == 2'h0 |-> FIXED_FREQ_VALID_O) else $error("valid low in engaged mode");
  a_valid_bypass_lo: assert property (
    byp && !BUS_DIVIDER_SEL_O[1] |-> FIXED_FREQ_VALID_O == ok) else $error("bad bypass valid");
  a_valid_bypass_hi: assert property (
    byp && BUS_DIVIDER_SEL_O[1] |-> FIXED_FREQ_VALID_O == ok) else $error("bad bypass valid");
  a_valid_no_mode: assert property (
    CLOCK_SOURCE_SEL_O == 2'h3 |-> !FIXED_FREQ_VALID_O) else $error("valid in unused mode");
  a_valid_follows: assert property (
    $stable(CLOCK_SOURCE_SEL_O) && $stable(REF_DIVIDER_SEL_O) && $stable(BUS_DIVIDER_SEL_O)
    |-> $stable(FIXED_FREQ_VALID_O)) else $error("valid moved without setting change");
  a_ext_gated_off: assert property (
    s_gate_off |-> !EXT_REF_CLOCK_OUT_O) else $error("ext output runs while gated");
  a_ext_follows_pin: assert property (
    s_gate_held |-> EXT_REF_CLOCK_OUT_O == $past(EXT_REF_I, 3)) else $error("ext output lost");
  a_stop_clocks_low: assert property (
    s_stopped |-> !FIXED_FREQ_CLOCK_O && !GENERATOR_OUTPUT_CLOCK_O) else $error("clock in stop");
endmodule // ecf_clock_ctrl_props

// ==== ecf_clock_ctrl_test.sv ====
`timescale 1ns/1ps
`include "ecf_consts.vh"
module ecf_clock_ctrl_test;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic       stop = 1'b0;
  logic       fll = 1'b0;
  logic       osc_run = 1'b1;
  wire  [7:0] rdata;
  wire        ext_ref, ext_out, ff_clk, ff_val, gen_clk, iref;
  wire  [1:0] clock_source_sel, bus_divider_sel;
  wire  [2:0] ref_divider_sel;
  int         bad_count = 0;
  int         check_count = 0;
  logic [7:0] d;
  int         np, no, nf, ng;
  always #25 mclk = ~mclk;
  always @(posedge mclk) fll <= ~fll;
  ecf_ext_osc #(.HALF_NS(500), .PHASE_NS(7)) ecf_ext_osc_inst (.run_i(osc_run), .clk_o(ext_ref));
  ecf_clock_ctrl #(.INT_REF_HALF_CYC(4)) ecf_clock_ctrl_inst (
    .MCLK_I(mclk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
    .RDATA_O(rdata), .EXT_REF_I(ext_ref), .FLL_CLK_I(fll), .STOP_I(stop),
    .EXT_REF_CLOCK_OUT_O(ext_out), .FIXED_FREQ_CLOCK_O(ff_clk), .FIXED_FREQ_VALID_O(ff_val),
    .GENERATOR_OUTPUT_CLOCK_O(gen_clk), .CLOCK_SOURCE_SEL_O(clock_source_sel),
    .INTERNAL_REF_SELECT_O(iref), .REF_DIVIDER_SEL_O(ref_divider_sel), .BUS_DIVIDER_SEL_O(bus_divider_sel));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task near(input int got, input int exp);
    chk({7'h00, got >= exp - 2 && got <= exp + 2}, 8'h01);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Counts transitions of pin, ext output, fixed clock and generator clock
  task count(input int n, output int cp, output int co, output int cf, output int cg);
    logic pp, po, pf, pg;
    cp = 0;
    co = 0;
    cf = 0;
    cg = 0;
    @(negedge mclk);
    {pp, po, pf, pg} = {ext_ref, ext_out, ff_clk, gen_clk};
    repeat (n) begin
      @(negedge mclk);
      cp += int'(ext_ref !== pp);
      co += int'(ext_out !== po);
      cf += int'(ff_clk !== pf);
      cg += int'(gen_clk !== pg);
      {pp, po, pf, pg} = {ext_ref, ext_out, ff_clk, gen_clk};
    end
  endtask
  task t_reset;
    rd(`ECF_ADDR_CTRL, d);
    chk(d, `ECF_CTRL_RESET);
    rd(`ECF_ADDR_DIV, d);
    chk(d, `ECF_DIV_RESET);
    chk({7'h00, ff_val}, 8'h01);
    rd(`ECF_ADDR_STATUS, d);
    chk(d, 8'h11);
    rd(8'h07, d);
    chk(d, 8'h00);
  endtask
  task t_valid;
    logic e;
    int   thr;
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 4; b++) begin
        for (int r = 0; r < 8; r++) begin
          wr(`ECF_ADDR_CTRL, {3'h0, m[1:0], 3'h4});
          wr(`ECF_ADDR_DIV, {2'h0, b[1:0], 1'b0, r[2:0]});
          thr = (b == 0) ? 2 : (b == 1) ? 3 : (b == 2) ? 4 : 5;
          e = (m == 0) || ((m == 1 || m == 2) && r >= thr);
          chk({7'h00, ff_val}, {7'h00, e});
          rd(`ECF_ADDR_STATUS, d);
          chk({7'h00, d[0]}, {7'h00, e});
        end
      end
    end
  endtask
  task t_ext;
    wr(`ECF_ADDR_DIV, 8'h00);
    wr(`ECF_ADDR_CTRL, 8'h0C);
    count(200, np, no, nf, ng);
    near(no, 0);
    near(nf, 50);
    chk({7'h00, ng >= 4 * nf}, 8'h00);
    wr(`ECF_ADDR_CTRL, 8'h0D);
    count(200, np, no, nf, ng);
    near(no, np);
    near(nf, 50);
    wr(`ECF_ADDR_CTRL, 8'h01);
    count(200, np, no, nf, ng);
    near(nf, np);
    near(ng, 200);
    chk({7'h00, ng >= 4 * nf}, 8'h01);
    rd(`ECF_ADDR_STATUS, d);
    chk(d, 8'h1B);
  endtask
  task t_stop;
    @(posedge mclk);
    stop <= 1'b1;
    count(200, np, no, nf, ng);
    near(no, 0);
    near(nf, 0);
    wr(`ECF_ADDR_CTRL, 8'h03);
    count(200, np, no, nf, ng);
    near(no, np);
    @(posedge mclk);
    stop <= 1'b0;
  endtask
  // Reference source halts: presence drops and the lost flag latches
  task t_lost;
    @(posedge mclk);
    osc_run <= 1'b0;
    repeat (700) @(posedge mclk);
    rd(`ECF_ADDR_FLAGS, d);
    chk(d, 8'h01);
    rd(`ECF_ADDR_STATUS, d);
    chk(d, 8'h19);
    wr(`ECF_ADDR_FLAGS, 8'h01);
    rd(`ECF_ADDR_FLAGS, d);
    chk(d, 8'h00);
    @(posedge mclk);
    osc_run <= 1'b1;
  endtask
  task print_verdict;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_valid;
    t_ext;
    t_stop;
    t_lost;
    print_verdict;
  end
endmodule // ecf_clock_ctrl_test
bind ecf_clock_ctrl ecf_clock_ctrl_props ecf_clock_ctrl_props_inst (
  .MCLK_I(MCLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .STOP_I(STOP_I), .EXT_REF_I(EXT_REF_I), .EXT_REF_CLOCK_OUT_O(EXT_REF_CLOCK_OUT_O),
  .FIXED_FREQ_CLOCK_O(FIXED_FREQ_CLOCK_O), .FIXED_FREQ_VALID_O(FIXED_FREQ_VALID_O),
  .GENERATOR_OUTPUT_CLOCK_O(GENERATOR_OUTPUT_CLOCK_O), .CLOCK_SOURCE_SEL_O(CLOCK_SOURCE_SEL_O),
  .REF_DIVIDER_SEL_O(REF_DIVIDER_SEL_O), .BUS_DIVIDER_SEL_O(BUS_DIVIDER_SEL_O));

// ==== ecf_consts.vh ====
`ifndef ECF_CONSTS_VH
`define ECF_CONSTS_VH

// Register offsets
`define ECF_ADDR_CTRL        8'h00
`define ECF_ADDR_DIV         8'h01
`define ECF_ADDR_STATUS      8'h02
`define ECF_ADDR_FLAGS       8'h03

// Control register fields
`define ECF_CTRL_OUT_EN      0
`define ECF_CTRL_STOP_EN     1
`define ECF_CTRL_IREF_SEL    2
`define ECF_CTRL_CLOCK_SOURCE_SEL_LO     3
`define ECF_CTRL_CLOCK_SOURCE_SEL_HI     4
`define ECF_CTRL_RESET       8'h04

// Divider register fields
`define ECF_DIV_REF_DIVIDER_SEL_LO      0
`define ECF_DIV_REF_DIVIDER_SEL_HI      2
`define ECF_DIV_BUS_DIVIDER_SEL_LO      4
`define ECF_DIV_BUS_DIVIDER_SEL_HI      5
`define ECF_DIV_RESET        8'h10

// Status register fields
`define ECF_STAT_FFV         0
`define ECF_STAT_EXT_PRESENT 1
`define ECF_STAT_STOP        2
`define ECF_STAT_EXT_OUT_ON  3
`define ECF_STAT_ENGAGED     4

// Sticky flag register fields
`define ECF_FLAG_EXT_LOST    0
`define ECF_FLAG_EXT_FAST    1

// Clock source select codes
`define ECF_CLOCK_SOURCE_SEL_FLL         2'h0
`define ECF_CLOCK_SOURCE_SEL_INT         2'h1
`define ECF_CLOCK_SOURCE_SEL_EXT         2'h2

// Lowest reference divider for valid flag, above the bus divider
`define ECF_FFV_REF_DIVIDER_SEL_OFFSET  3'h2

// Timing
`define ECF_CLK_PERIOD_NS        50
`define ECF_EXT_REF_MAX_PERIOD_NS 32000
`define ECF_EXT_REF_MIN_PERIOD_NS 200
`define ECF_EXT_TIMEOUT_CYC  (`ECF_EXT_REF_MAX_PERIOD_NS / `ECF_CLK_PERIOD_NS)
`define ECF_EXT_MIN_CYC      ((`ECF_EXT_REF_MIN_PERIOD_NS + `ECF_CLK_PERIOD_NS - 1) / `ECF_CLK_PERIOD_NS)

// Internal reference half period in system clocks
`define ECF_INT_REF_HALF_CYC 320

`endif

// ==== ecf_edge_div.v ====
`timescale 1ns/1ps
// Divides a stream of source transitions by two to the power of sel
module ecf_edge_div #(
  parameter CNT_W = 7,
  parameter SEL_W = 3
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire             run_i,
  input  wire             edge_i,
  input  wire [SEL_W-1:0] sel_i,
  output reg              clk_o
);

  reg  [CNT_W-1:0] cnt;
  wire [CNT_W-1:0] mask;
  wire             wrap;

  assign mask = ~({CNT_W{1'b1}} << sel_i);
  assign wrap = ((cnt | ~mask) == {CNT_W{1'b1}});

  always @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      cnt   <= {CNT_W{1'b0}};
      clk_o <= 1'b0;
    end else if (edge_i) begin
      if (wrap) begin
        cnt   <= {CNT_W{1'b0}};
        clk_o <= ~clk_o;
      end else begin
        cnt   <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // ecf_edge_div

// ==== ecf_ext_osc.sv ====
`timescale 1ns/1ps
// External reference source, held low while not running
module ecf_ext_osc #(
  parameter HALF_NS  = 500,
  parameter PHASE_NS = 7
) (
  input  wire run_i,
  output reg  clk_o
);
  initial begin
    clk_o = 1'b0;
    if (HALF_NS < 100 || HALF_NS > 16000) begin
      $display("Reference half period out of range");
    end
    #(PHASE_NS);
    forever begin
      #(HALF_NS);
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end
endmodule // ecf_ext_osc
